/* acquisition_trigger_busy_logic_tb.sv */
// Purpose: Self-checking bench of the trigger, buffer and busy core.
// Assumes: Small memory of 64 samples so that a buffer refill stays short.
// Notes: Samples flow except during the register test's FIFO drain; the memory model answers slowly.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================================
// Bench top.
module acquisition_trigger_busy_logic_tb;
   logic clk, rst_b, wr, rd, buf_free, sv, ext, hold, slow, ce;
   logic [17:0] maddr;
   logic rvalid, srdy, mrdy, we, general_output_pin, busy, full, acc;
   logic [15:0] addr;
   logic [31:0] wdata, rdata;
   logic [383:0] smp, mdata;
   int errors, n_checks, n_acc, a0, nw, writes, n_gpo, g0;

   atbl_core #(.MEM_DEPTH(64)) dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_post_trigger_count(18'h00004),
      .i_buf_free(buf_free), .i_sample_valid(sv), .o_sample_ready(srdy), .i_samples(smp),
      .i_mem_ready(mrdy), .o_mem_we(we), .o_mem_addr(maddr), .o_mem_data(mdata),
      .i_ext_trigger_input(ext), .o_general_output_pin(general_output_pin), .o_busy(busy),
      .o_full(full), .o_trig_accepted(acc));
   atbl_mem_model mem_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_hold(hold), .i_slow(slow),
      .i_mem_we(we), .o_mem_ready(mrdy), .o_writes(writes));

   // Clock of 4 ns period.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Count accepted trigger and general output pulses, one per high cycle.
   always @(posedge clk) begin
      if (acc === 1'b1) n_acc++;
      if (general_output_pin === 1'b1) n_gpo++;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic rst;
      rst_b = 1'b0;
      cyc(8);
      rst_b = 1'b1;
      cyc(2);
      a0 = n_acc;
      g0 = n_gpo;
   endtask : rst
   task automatic wreg(input logic [15:0] a, input logic [31:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask : wreg
   task automatic rreg(input logic [15:0] a, input logic [31:0] e);
      addr = a;
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      for (int k = 0; k < 3 && rvalid !== 1'b1; k++) cyc(1);
      `CHK(rvalid, 1'b1)
      `CHK(rdata, e)
      cyc(1);
   endtask : rreg
   task automatic swt;
      wreg(16'h8108, 32'h00000001);
   endtask : swt
   task automatic pfree;
      buf_free = 1'b1;
      cyc(1);
      buf_free = 1'b0;
   endtask : pfree
   task automatic stop_test;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   // Reset values, write-only and unmapped reads, FIFO fill and drain.
   task automatic t_regs;
      rst;
      smp = {32{12'h5a3}};
      rreg(16'h810c, 32'hc0000000);
      rreg(16'h8110, 32'h80000000);
      rreg(16'h8108, 32'h00000000);
      rreg(16'h7ff0, 32'h00000000);
      hold = 1'b1;
      cyc(12);
      `CHK(srdy, 1'b0)
      nw = writes;
      sv = 1'b0;
      hold = 1'b0;
      cyc(24);
      `CHK(writes - nw, 8)
      `CHK(srdy, 1'b1)
      `CHK(maddr, 18'((writes - 1) % 64))
      `CHK(mdata, {32{12'h5a3}})
      sv = 1'b1;
      smp = '0;
      // A write while the clock enable is low must not land.
      ce = 1'b0;
      wreg(16'h816c, 32'h00000005);
      ce = 1'b1;
      rreg(16'h816c, 32'h00000000);
      $display("test regs done");
   endtask : t_regs
   // One buffer: trigger, freeze, full, free, refill wait.
   task automatic t_full;
      rst;
      swt;
      cyc(3);
      `CHK(n_acc - a0, 1)
      `CHK(n_gpo - g0, 1)
      cyc(20);
      `CHK(full, 1'b1)
      nw = writes;
      swt;
      cyc(10);
      `CHK(writes - nw, 0)
      `CHK(n_acc - a0, 1)
      pfree;
      cyc(4);
      `CHK(full, 1'b0)
      swt;
      cyc(4);
      `CHK(n_acc - a0, 1)
      `CHK(writes > nw, 1'b1)
      cyc(150);
      swt;
      cyc(4);
      `CHK(n_acc - a0, 2)
      $display("test full done");
   endtask : t_full
   // Early full with two buffers.
   task automatic t_early;
      rst;
      wreg(16'h800c, 32'h00000001);
      wreg(16'h8100, 32'h00000020);
      swt;
      cyc(20);
      `CHK(full, 1'b1)
      nw = writes;
      swt;
      cyc(8);
      `CHK(writes > nw, 1'b1)
      `CHK(n_acc - a0, 1)
      pfree;
      cyc(2);
      swt;
      cyc(3);
      `CHK(n_acc - a0, 2)
      $display("test early done");
   endtask : t_early
   // Almost-full busy routed to the general output.
   task automatic t_almost;
      rst;
      wreg(16'h800c, 32'h00000002);
      wreg(16'h816c, 32'h00000001);
      wreg(16'h811c, 32'h00100000);
      swt;
      cyc(20);
      `CHK(busy, 1'b1)
      `CHK(full, 1'b0)
      `CHK(general_output_pin, 1'b1)
      swt;
      cyc(3);
      `CHK(n_acc - a0, 2)
      $display("test almost done");
   endtask : t_almost
   // External trigger disabled, then enabled with its synchroniser delay.
   task automatic t_ext;
      rst;
      wreg(16'h810c, 32'h80000000);
      ext = 1'b1;
      cyc(6);
      ext = 1'b0;
      cyc(2);
      `CHK(n_acc - a0, 0)
      wreg(16'h810c, 32'h40000000);
      ext = 1'b1;
      cyc(2);
      `CHK(n_acc - a0, 0)
      cyc(4);
      `CHK(n_acc - a0, 1)
      ext = 1'b0;
      $display("test ext done");
   endtask : t_ext
   // Self-trigger through the channel mask, then majority with zero window.
   task automatic t_self;
      rst;
      wreg(16'h1080, 32'h00000100);
      wreg(16'h10a8, 32'h00000001);
      wreg(16'h810c, 32'h00000001);
      swt;
      smp[23:12] = 12'h200;
      cyc(30);
      `CHK(n_acc - a0, 0)
      smp[11:0] = 12'h200;
      cyc(30);
      `CHK(n_acc - a0, 1)
      smp = '0;
      rst;
      wreg(16'h1080, 32'h00000100);
      wreg(16'h1180, 32'h00000100);
      wreg(16'h10a8, 32'h00000001);
      wreg(16'h11a8, 32'h00000001);
      rreg(16'h1180, 32'h00000100);
      rreg(16'h11a8, 32'h00000001);
      wreg(16'h810c, 32'h01000003);
      smp[11:0] = 12'h200;
      cyc(30);
      `CHK(n_acc - a0, 0)
      smp = '0;
      cyc(4);
      smp[11:0] = 12'h200;
      smp[107:96] = 12'h200;
      cyc(30);
      `CHK(n_acc - a0, 1)
      smp = '0;
      // Below-threshold direction: idle samples of zero fire channel 0.
      rst;
      wreg(16'h1080, 32'h00000100);
      wreg(16'h10a8, 32'h00000001);
      wreg(16'h810c, 32'h00000001);
      wreg(16'h8000, 32'h00000040);
      cyc(30);
      `CHK(n_acc - a0, 1)
      $display("test self done");
   endtask : t_self

   // Main sequence.
   initial begin
      {rst_b, wr, rd, buf_free, ext, hold} = '0;
      {sv, slow, ce} = 3'b111;
      addr = '0;
      wdata = '0;
      smp = '0;
      t_regs;
      t_full;
      t_early;
      t_almost;
      t_ext;
      t_self;
      stop_test;
   end
   // Watchdog against a hang.
   initial begin
      #20000;
      errors++;
      stop_test;
   end
endmodule : acquisition_trigger_busy_logic_tb
`default_nettype wire

/* atbl_cfg.svh */
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Core clock period of 4 ns; trigger clock step of 8 ns.
// Notes: Definitions only; included by bare name.
`ifndef ATBL_CFG_SVH
`define ATBL_CFG_SVH
// ==========================================================================
// Register offsets
`define ATBL_OFS_GRP_THR 16'h1080
`define ATBL_OFS_GRP_MASK 16'h10a8
`define ATBL_OFS_CH_CFG 16'h8000
`define ATBL_OFS_BUF_ORG 16'h800c
`define ATBL_OFS_ACQ_CTRL 16'h8100
`define ATBL_OFS_ACQ_STAT 16'h8104
`define ATBL_OFS_SW_TRIG 16'h8108
`define ATBL_OFS_TRG_EN 16'h810c
`define ATBL_OFS_TRGOUT_EN 16'h8110
`define ATBL_OFS_FP_IO 16'h811c
`define ATBL_OFS_ALMOST 16'h816c
// ==========================================================================
// Field positions
`define ATBL_BIT_UNDER 6
`define ATBL_BIT_EARLY 5
`define ATBL_BIT_SW 31
`define ATBL_BIT_EXT 30
`define ATBL_WIN_LSB 20
`define ATBL_MAJ_LSB 24
`define ATBL_OUT_LOGIC_LSB 8
`define ATBL_OUT_MAJ_LSB 10
`define ATBL_FP_MODE_LSB 16
`define ATBL_FP_BUSY 20
// ==========================================================================
// Reset values and limits
`define ATBL_TRG_EN_RST 32'hc0000000
`define ATBL_TRGOUT_RST 32'h80000000
`define ATBL_MAX_BUF_CODE 4'ha
// ==========================================================================
// Timing
`define ATBL_TRG_STEP_NS 8
`define ATBL_CLK_NS 4
`define ATBL_WIN_STEP_CYC ((`ATBL_TRG_STEP_NS + `ATBL_CLK_NS - 1) / `ATBL_CLK_NS)
`endif

/* atbl_core.sv */
// Purpose: Board trigger, buffer management and busy logic of the digitizer.
// Assumes: Samples and pins synchronous to i_core_clk except the external trigger.
// Notes: The sample memory itself sits outside; this block drives its write port.
`include "atbl_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Sample FIFO with valid and ready on both sides.
module atbl_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock, reset and enable.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Filling side.
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // Draining side.
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } atbl_fifo_st_t;
   atbl_fifo_st_t s;
   atbl_fifo_st_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Honest full and empty flags drive the handshakes.
   assign o_ready = (s.cnt != (AW+1)'(DEPTH));
   assign o_valid = (s.cnt != '0);
   assign o_data = mem[s.rd];
   assign push = i_valid & o_ready & i_ce;
   assign pop = o_valid & i_ready & i_ce;

   // Pointer and count update.
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
      end
      next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   // Storage array.
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[s.wr] <= i_data;
      end
   end
endmodule : atbl_fifo

// ==========================================================================
// Trigger, buffer and busy core.
module atbl_core import atbl_pkg::*; #(
   parameter int NCH = 32,
   parameter int SW = 12,
   parameter int MEM_DEPTH = 196608,
   parameter int FIFO_DEPTH = 8
) (
   // Clock, reset and enable.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Register access port.
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Acquisition control and readout side.
   input wire logic [17:0] i_post_trigger_count,
   input wire logic i_buf_free,
   // Converter samples.
   input wire logic i_sample_valid,
   output logic o_sample_ready,
   input wire logic [NCH*SW-1:0] i_samples,
   // Sample memory write port.
   input wire logic i_mem_ready,
   output logic o_mem_we,
   output logic [17:0] o_mem_addr,
   output logic [NCH*SW-1:0] o_mem_data,
   // Front panel and status.
   input wire logic i_ext_trigger_input,
   output logic o_general_output_pin,
   output logic o_busy,
   output logic o_full,
   output logic o_trig_accepted
);
   localparam int NG = 4;
   localparam int GW = NCH / NG;

   typedef struct packed {
      logic [NG-1:0][SW-1:0] grp_thr;
      logic [NG-1:0][GW-1:0] grp_mask;
      logic [31:0] ch_cfg;
      logic [3:0] buf_code;
      logic [31:0] acq_ctrl;
      logic [31:0] trg_en;
      logic [31:0] trgout_en;
      logic [31:0] fp_io;
      logic [10:0] almost;
      logic sw_pulse;
      logic ext_s1;
      logic ext_s2;
      logic ext_s3;
      logic [NG-1:0] req_prev;
      logic [NG-1:0][4:0] stretch;
      atbl_state_t st;
      logic wait_fill;
      logic [10:0] frozen;
      logic [9:0] wbuf;
      logic [17:0] offset;
      logic [17:0] post_left;
      logic trig_acc;
      logic general_output_pin;
      logic busy;
      logic mem_we;
      logic [17:0] mem_addr;
      logic [NCH*SW-1:0] mem_data;
      logic [31:0] rdata;
      logic rvalid;
   } atbl_st_t;

   atbl_st_t s;
   atbl_st_t next_s;
   logic fifo_valid;
   logic fifo_ready;
   logic [NCH*SW-1:0] fifo_data;
   logic tick;
   logic [NCH-1:0] channel_self_trigger;
   logic [NG-1:0] req_raw;
   logic [NG-1:0] stretched;
   logic [2:0] coinc_cnt;
   logic [2:0] maj_lvl;
   logic [3:0] win;
   logic [10:0] nb;
   logic [17:0] buf_size;
   logic early;
   logic is_full;
   logic busy_now;
   logic ext_edge;
   logic grp_term;
   logic cmn_trig;
   logic trig_ok;
   logic out_grp;
   logic free_ok;
   logic freeze;

   // ========================================================================
   // Sample FIFO; memory back-pressure stalls it, full-state discard drains.
   atbl_fifo #(.WIDTH(NCH*SW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_valid(i_sample_valid),
      .o_ready(o_sample_ready),
      .i_data(i_samples),
      .o_valid(fifo_valid),
      .i_ready(fifo_ready),
      .o_data(fifo_data)
   );
   assign fifo_ready = i_mem_ready | (s.st == ST_STOP);
   assign tick = fifo_valid & fifo_ready & i_ce;

   // ========================================================================
   // Per-channel threshold compare against the group threshold.
   for (genvar c = 0; c < NCH; c++) begin : g_chan
      logic [SW-1:0] smp;
      logic over;
      assign smp = fifo_data[c*SW +: SW];
      assign over = smp > s.grp_thr[c / GW];
      assign channel_self_trigger[c] = s.ch_cfg[`ATBL_BIT_UNDER] ? (smp < s.grp_thr[c / GW]) : over;
   end

   // Group requests and coincidence counting.
   always_comb begin
      coinc_cnt = '0;
      for (int g = 0; g < NG; g++) begin
         req_raw[g] = tick & |(channel_self_trigger[g*GW +: GW] & s.grp_mask[g]);
         stretched[g] = s.trg_en[g] & (req_raw[g] | (s.stretch[g] != '0));
         coinc_cnt = coinc_cnt + {2'b00, stretched[g]};
      end
   end

   // ========================================================================
   // Field decode and occupancy thresholds.
   assign maj_lvl = s.trg_en[`ATBL_MAJ_LSB +: 3];
   assign win = s.trg_en[`ATBL_WIN_LSB +: 4];
   assign nb = 11'h001 << s.buf_code;
   assign buf_size = 18'(MEM_DEPTH >> s.buf_code);
   assign early = s.acq_ctrl[`ATBL_BIT_EARLY];
   assign is_full = early ? (s.frozen >= nb - 11'h001) : (s.frozen >= nb);
   assign busy_now = is_full | ((s.almost != '0) & (s.frozen >= s.almost));
   assign ext_edge = s.ext_s2 & ~s.ext_s3;
   assign grp_term = (maj_lvl == '0) ? |(req_raw & s.trg_en[NG-1:0])
                                     : (coinc_cnt > maj_lvl);
   assign cmn_trig = (s.trg_en[`ATBL_BIT_SW] & s.sw_pulse)
                   | (s.trg_en[`ATBL_BIT_EXT] & ext_edge)
                   | grp_term;
   assign trig_ok = cmn_trig & ~is_full & ~s.wait_fill & (s.st == ST_PRE);
   assign free_ok = i_buf_free & (s.frozen != '0);
   assign freeze = tick & (s.st == ST_POST) & (s.post_left <= 18'h00001);

   // Trigger-out group logic: OR, AND or majority of the enabled requests.
   always_comb begin
      case (s.trgout_en[`ATBL_OUT_LOGIC_LSB +: 2])
         2'b01: out_grp = (s.trgout_en[NG-1:0] != '0)
                        & ((req_raw & s.trgout_en[NG-1:0]) == s.trgout_en[NG-1:0]);
         2'b10: out_grp = coinc_cnt > s.trgout_en[`ATBL_OUT_MAJ_LSB +: 3];
         default: out_grp = |(req_raw & s.trgout_en[NG-1:0]);
      endcase
   end

   // ========================================================================
   // Next-state logic: registers, triggers and buffer management.
   always_comb begin
      next_s = s;
      next_s.sw_pulse = 1'b0;
      next_s.rvalid = 1'b0;
      next_s.mem_we = 1'b0;
      next_s.trig_acc = trig_ok;
      // Synchroniser for the external trigger input.
      next_s.ext_s1 = i_ext_trigger_input;
      next_s.ext_s2 = s.ext_s1;
      next_s.ext_s3 = s.ext_s2;
      // Request stretching over the coincidence window.
      for (int g = 0; g < NG; g++) begin
         // Edges are taken between samples, not between idle clock cycles.
         next_s.req_prev[g] = tick ? req_raw[g] : s.req_prev[g];
         if (req_raw[g] & ~s.req_prev[g]) begin
            next_s.stretch[g] = 5'(win * `ATBL_WIN_STEP_CYC);
         end else if (s.stretch[g] != '0) begin
            next_s.stretch[g] = s.stretch[g] - 5'h01;
         end
      end
      // Register writes.
      if (i_reg_wr) begin
         if (i_reg_addr[15:12] == 4'h1 && i_reg_addr[11:8] < 4'h4) begin
            if (i_reg_addr[7:0] == 8'(`ATBL_OFS_GRP_THR)) begin
               next_s.grp_thr[i_reg_addr[9:8]] = i_reg_wdata[SW-1:0];
            end else if (i_reg_addr[7:0] == 8'(`ATBL_OFS_GRP_MASK)) begin
               next_s.grp_mask[i_reg_addr[9:8]] = i_reg_wdata[GW-1:0];
            end
         end
         case (i_reg_addr)
            `ATBL_OFS_CH_CFG: next_s.ch_cfg = i_reg_wdata;
            `ATBL_OFS_BUF_ORG: next_s.buf_code = (i_reg_wdata[3:0] > `ATBL_MAX_BUF_CODE)
                                                 ? `ATBL_MAX_BUF_CODE : i_reg_wdata[3:0];
            `ATBL_OFS_ACQ_CTRL: next_s.acq_ctrl = i_reg_wdata;
            `ATBL_OFS_SW_TRIG: next_s.sw_pulse = 1'b1;
            `ATBL_OFS_TRG_EN: next_s.trg_en = i_reg_wdata;
            `ATBL_OFS_TRGOUT_EN: next_s.trgout_en = i_reg_wdata;
            `ATBL_OFS_FP_IO: next_s.fp_io = i_reg_wdata;
            `ATBL_OFS_ALMOST: next_s.almost = i_reg_wdata[10:0];
            default: ;
         endcase
      end
      // Register reads answer one cycle later.
      if (i_reg_rd) begin
         next_s.rvalid = 1'b1;
         case (i_reg_addr)
            `ATBL_OFS_CH_CFG: next_s.rdata = s.ch_cfg;
            `ATBL_OFS_BUF_ORG: next_s.rdata = {28'h0000000, s.buf_code};
            `ATBL_OFS_ACQ_CTRL: next_s.rdata = s.acq_ctrl;
            `ATBL_OFS_ACQ_STAT: next_s.rdata = {17'h00000, s.wait_fill, is_full, busy_now,
                                                1'b0, s.frozen};
            `ATBL_OFS_TRG_EN: next_s.rdata = s.trg_en;
            `ATBL_OFS_TRGOUT_EN: next_s.rdata = s.trgout_en;
            `ATBL_OFS_FP_IO: next_s.rdata = s.fp_io;
            `ATBL_OFS_ALMOST: next_s.rdata = {21'h000000, s.almost};
            default: next_s.rdata = 32'h00000000;
         endcase
         if (i_reg_addr[15:12] == 4'h1 && i_reg_addr[11:10] == 2'b00) begin
            if (i_reg_addr[7:0] == 8'(`ATBL_OFS_GRP_THR)) begin
               next_s.rdata = 32'(s.grp_thr[i_reg_addr[9:8]]);
            end else if (i_reg_addr[7:0] == 8'(`ATBL_OFS_GRP_MASK)) begin
               next_s.rdata = 32'(s.grp_mask[i_reg_addr[9:8]]);
            end
         end
      end
      // Sample write into the current buffer.
      if (tick && s.st != ST_STOP) begin
         next_s.mem_we = 1'b1;
         next_s.mem_addr = 18'(28'(s.wbuf) * 28'(buf_size)) + s.offset;
         next_s.mem_data = fifo_data;
         next_s.offset = (s.offset >= buf_size - 18'h00001) ? '0 : s.offset + 18'h00001;
         if (s.wait_fill && s.offset >= buf_size - 18'h00001) begin
            next_s.wait_fill = 1'b0;
         end
      end
      // Acquisition state machine.
      case (s.st)
         ST_PRE: begin
            if (trig_ok) begin
               next_s.post_left = i_post_trigger_count;
               next_s.st = ST_POST;
            end
         end
         ST_POST: begin
            if (tick) begin
               next_s.post_left = s.post_left - 18'h00001;
            end
            if (freeze) begin
               next_s.offset = '0;
               next_s.wbuf = (11'(s.wbuf) >= nb - 11'h001) ? '0 : s.wbuf + 10'h001;
               next_s.st = (s.frozen + 11'h001 >= nb && !free_ok) ? ST_STOP : ST_PRE;
            end
         end
         ST_STOP: begin
            if (free_ok) begin
               next_s.st = ST_PRE;
               next_s.offset = '0;
               next_s.wait_fill = ~early;
            end
         end
         default: next_s.st = ST_PRE;
      endcase
      next_s.frozen = s.frozen + {10'h000, freeze} - {10'h000, free_ok};
      // Busy and general output selection.
      next_s.busy = busy_now;
      if (s.fp_io[`ATBL_FP_BUSY] || s.fp_io[`ATBL_FP_MODE_LSB +: 4] == 4'h7) begin
         next_s.general_output_pin = busy_now;
      end else begin
         next_s.general_output_pin = (s.trgout_en[`ATBL_BIT_SW] & s.sw_pulse)
                    | (s.trgout_en[`ATBL_BIT_EXT] & ext_edge) | out_grp;
      end
   end

   // ========================================================================
   // State register; reset value enables software and external triggers.
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
         s.trg_en <= `ATBL_TRG_EN_RST;
         s.trgout_en <= `ATBL_TRGOUT_RST;
         s.st <= ST_PRE;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   // Output assignments.
   assign o_reg_rdata = s.rdata;
   assign o_reg_rvalid = s.rvalid;
   assign o_mem_we = s.mem_we;
   assign o_mem_addr = s.mem_addr;
   assign o_mem_data = s.mem_data;
   assign o_general_output_pin = s.general_output_pin;
   assign o_busy = s.busy;
   assign o_full = is_full;
   assign o_trig_accepted = s.trig_acc;

   // ========================================================================
   // Checks on the trigger and buffer behaviour.
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   full_reject_a: assert property (i_ce & is_full |=> !s.trig_acc)
      else $error("Trigger accepted while full.");
   stop_discard_a: assert property (i_ce & s.st == ST_STOP |=> !s.mem_we)
      else $error("Sample written while stopped.");
   sw_pulse_a: assert property (i_ce & i_reg_wr & i_reg_addr == `ATBL_OFS_SW_TRIG
                                |=> s.sw_pulse ##1 (!s.sw_pulse | !i_ce | $past(i_reg_wr)))
      else $error("Software trigger pulse wrong.");
   almost_busy_a: assert property (i_ce & s.almost != '0 & s.frozen >= s.almost
                                   |=> s.busy)
      else $error("Almost-full level did not raise busy.");
   early_full_a: assert property (early & s.frozen == nb - 11'h001 |-> is_full)
      else $error("Early-full did not declare full.");
   or_mode_a: assert property (maj_lvl == '0 & |(req_raw & s.trg_en[NG-1:0])
                               |-> cmn_trig)
      else $error("Enabled request missed in OR mode.");
   src_gate_a: assert property (cmn_trig |-> (s.sw_pulse & s.trg_en[`ATBL_BIT_SW])
                                | (ext_edge & s.trg_en[`ATBL_BIT_EXT]) | |stretched
                                | |(req_raw & s.trg_en[NG-1:0]))
      else $error("Trigger from a disabled source.");
   wait_fill_a: assert property (i_ce & s.wait_fill |=> !s.trig_acc)
      else $error("Trigger accepted before buffer refilled.");
   resume_a: assert property (i_ce & s.st == ST_STOP & free_ok |=> s.st == ST_PRE)
      else $error("Free buffer did not resume acquisition.");

   trig_c: cover property (s.trig_acc);
   full_c: cover property (s.st == ST_STOP ##[1:200] s.st == ST_PRE);
   refill_c: cover property ($fell(s.wait_fill));
   maj_c: cover property (maj_lvl != '0 & grp_term);
endmodule : atbl_core
`default_nettype wire

/* atbl_mem_model.sv */
// Purpose: Far-side sample memory that accepts the core's write pulses.
// Assumes: At most one write per clock cycle.
// Notes: Answers promptly, every other cycle, or stalls while held.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Memory sink with a settable pace.
module atbl_mem_model (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Pace control.
   input wire logic i_hold,
   input wire logic i_slow,
   // Write port.
   input wire logic i_mem_we,
   output logic o_mem_ready,
   output var int o_writes
);
   logic tog;
   // Ready is withheld while held and on every other cycle when slow.
   assign o_mem_ready = !i_hold && (!i_slow || tog);
   // Count accepted writes and step the pace.
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tog <= 1'b0;
         o_writes <= 0;
      end else begin
         tog <= !tog;
         if (i_mem_we) o_writes <= o_writes + 1;
      end
   end
endmodule : atbl_mem_model
`default_nettype wire

/* atbl_pkg.sv */
// Purpose: Shared types of the acquisition trigger and busy logic.
// Assumes: Nothing beyond the configuration header.
// Notes: Acquisition state only.
`default_nettype none
package atbl_pkg;
   // ========================================================================
   // Acquisition states: pre-trigger, post-trigger, stopped while full.
   typedef enum logic [1:0] {ST_PRE, ST_POST, ST_STOP} atbl_state_t;
endpackage : atbl_pkg
`default_nettype wire
